// File: pkg/pio_map.vh
`ifndef PIO_MAP_VH
`define PIO_MAP_VH
// Register byte addresses on the Wishbone slave.
`define PIO_ADDR_P2_DATA      8'ha0
`define PIO_ADDR_P1_DRIVE     8'ha5
`define PIO_ADDR_P2_DRIVE     8'ha6
`define PIO_ADDR_P1_MASK      8'hbf
`define PIO_ADDR_P1_VALUE     8'hcf
`define PIO_ADDR_P1_BYPASS    8'hd5
`define PIO_ADDR_P2_BYPASS    8'hd6
`define PIO_ADDR_P2_ANALOG    8'hf3
`define PIO_ADDR_P1_DATA      8'h90
`define PIO_ADDR_P1_ANALOG    8'hf2
`define PIO_ADDR_MATCH_CTRL   8'he0
// Reset values.
`define PIO_RST_P2_DATA       8'hff
`define PIO_RST_P1_DRIVE      8'h00
`define PIO_RST_P2_DRIVE      8'h00
`define PIO_RST_P1_MASK       8'h00
`define PIO_RST_P1_VALUE      8'hff
`define PIO_RST_P1_BYPASS     8'h00
`define PIO_RST_P2_BYPASS     8'h00
`define PIO_RST_P2_ANALOG     8'hff
`define PIO_RST_P1_DATA       8'hff
`define PIO_RST_P1_ANALOG     8'hff
`define PIO_RST_MATCH_CTRL    8'h00
// Match control fields.
`define PIO_MCTRL_INT_EN_BIT  0
`define PIO_MCTRL_EVENT_BIT   1
`endif

// File: verilog/pio_pin_cell.v
`timescale 1ns/10ps
// One pad's driver and receiver control, shared by both ports.
module pio_pin_cell
(
    input  wire sys_clk_in,
    input  wire rstn_in,
    input  wire latch_in,
    input  wire push_pull_in,
    input  wire digital_in,
    input  wire pad_in,
    output reg  pad_out,
    output reg  pad_oe_out,
    output reg  pullup_en_out,
    output reg  read_out
);
    // Drive low on 0; drive high on 1 only when push-pull; analog turns all off.
    always @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            pad_out       <= 1'b1;
            pad_oe_out    <= 1'b0;
            pullup_en_out <= 1'b0;
            read_out      <= 1'b0;
        end
        else
        begin
            pad_out       <= latch_in;
            pad_oe_out    <= digital_in & (~latch_in | push_pull_in);
            pullup_en_out <= digital_in & latch_in & ~push_pull_in;
            read_out      <= digital_in & pad_in;
        end
    end
endmodule

// File: verilog/pio_port_top.v
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/10ps
`include "pio_map.vh"
module pio_port_top
#(
    parameter WIDTH = 8
)
(
    input  wire             sys_clk_in,
    input  wire             rstn_in,
    input  wire [7:0]       wb_adr_in,
    input  wire [7:0]       wb_dat_in,
    input  wire             wb_we_in,
    input  wire             wb_sel_in,
    input  wire             wb_cyc_in,
    input  wire             wb_stb_in,
    output reg  [7:0]       wb_dat_out,
    output reg              wb_ack_out,
    input  wire [WIDTH-1:0] p1_pad_in,
    output wire [WIDTH-1:0] p1_pad_out,
    output wire [WIDTH-1:0] p1_pad_oe_out,
    output wire [WIDTH-1:0] p1_pullup_en_out,
    input  wire [WIDTH-1:0] p2_pad_in,
    output wire [WIDTH-1:0] p2_pad_out,
    output wire [WIDTH-1:0] p2_pad_oe_out,
    output wire [WIDTH-1:0] p2_pullup_en_out,
    output reg  [WIDTH-1:0] p1_bypass_out,
    output reg  [WIDTH-1:0] p2_bypass_out,
    output reg              match_event_out,
    output reg              match_irq_out,
    output reg              wake_out
);
    reg  [WIDTH-1:0] p1_data_latch_r;
    reg  [WIDTH-1:0] p1_analog_select_r;
    reg  [WIDTH-1:0] port1_drive_style_r;
    reg  [WIDTH-1:0] port1_compare_mask_r;
    reg  [WIDTH-1:0] port1_compare_value_r;
    reg  [WIDTH-1:0] port2_data_latch_r;
    reg  [WIDTH-1:0] port2_analog_select_r;
    reg  [WIDTH-1:0] port2_drive_style_r;
    reg              match_interrupt_enable_r;
    reg              match_sticky_r;
    reg  [7:0]       rd_nxt;
    wire [WIDTH-1:0] p1_read;
    wire [WIDTH-1:0] p2_read;
    wire             wr_en;
    wire             mismatch;

    // A request is taken once; the ack pulse splits back-to-back cycles.
    assign wr_en = wb_cyc_in & wb_stb_in & wb_we_in & wb_sel_in & ~wb_ack_out;

    // Masked pin pattern compared against the stored pattern.
    assign mismatch = |((p1_pad_in & port1_compare_mask_r) ^
                        (port1_compare_value_r & port1_compare_mask_r));

    // One pin cell per bit of each port.
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1)
        begin : g_pin
            pio_pin_cell u_p1
            (
                .sys_clk_in    (sys_clk_in),
                .rstn_in       (rstn_in),
                .latch_in      (p1_data_latch_r[gi]),
                .push_pull_in  (port1_drive_style_r[gi]),
                .digital_in    (p1_analog_select_r[gi]),
                .pad_in        (p1_pad_in[gi]),
                .pad_out       (p1_pad_out[gi]),
                .pad_oe_out    (p1_pad_oe_out[gi]),
                .pullup_en_out (p1_pullup_en_out[gi]),
                .read_out      (p1_read[gi])
            );
            pio_pin_cell u_p2
            (
                .sys_clk_in    (sys_clk_in),
                .rstn_in       (rstn_in),
                .latch_in      (port2_data_latch_r[gi]),
                .push_pull_in  (port2_drive_style_r[gi]),
                .digital_in    (port2_analog_select_r[gi]),
                .pad_in        (p2_pad_in[gi]),
                .pad_out       (p2_pad_out[gi]),
                .pad_oe_out    (p2_pad_oe_out[gi]),
                .pullup_en_out (p2_pullup_en_out[gi]),
                .read_out      (p2_read[gi])
            );
        end
    endgenerate

    // Register writes take effect on the acknowledging edge.
    always @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            p1_data_latch_r          <= `PIO_RST_P1_DATA;
            p1_analog_select_r       <= `PIO_RST_P1_ANALOG;
            port1_drive_style_r      <= `PIO_RST_P1_DRIVE;
            port1_compare_mask_r     <= `PIO_RST_P1_MASK;
            port1_compare_value_r    <= `PIO_RST_P1_VALUE;
            p1_bypass_out            <= `PIO_RST_P1_BYPASS;
            port2_data_latch_r       <= `PIO_RST_P2_DATA;
            port2_analog_select_r    <= `PIO_RST_P2_ANALOG;
            port2_drive_style_r      <= `PIO_RST_P2_DRIVE;
            p2_bypass_out            <= `PIO_RST_P2_BYPASS;
            match_interrupt_enable_r <= 1'b0;
        end
        else if (wr_en)
        begin
            case (wb_adr_in)
                `PIO_ADDR_P1_DATA:    p1_data_latch_r       <= wb_dat_in;
                `PIO_ADDR_P1_ANALOG:  p1_analog_select_r    <= wb_dat_in;
                `PIO_ADDR_P1_DRIVE:   port1_drive_style_r   <= wb_dat_in;
                `PIO_ADDR_P1_MASK:    port1_compare_mask_r  <= wb_dat_in;
                `PIO_ADDR_P1_VALUE:   port1_compare_value_r <= wb_dat_in;
                `PIO_ADDR_P1_BYPASS:  p1_bypass_out         <= wb_dat_in;
                `PIO_ADDR_P2_DATA:    port2_data_latch_r    <= wb_dat_in;
                `PIO_ADDR_P2_ANALOG:  port2_analog_select_r <= wb_dat_in;
                `PIO_ADDR_P2_DRIVE:   port2_drive_style_r   <= wb_dat_in;
                `PIO_ADDR_P2_BYPASS:  p2_bypass_out         <= wb_dat_in;
                `PIO_ADDR_MATCH_CTRL:
                    match_interrupt_enable_r <= wb_dat_in[`PIO_MCTRL_INT_EN_BIT];
                default:              ;
            endcase
        end
    end

    // Read multiplexer; unmapped addresses read zero.
    always @*
    begin
        case (wb_adr_in)
            `PIO_ADDR_P1_DATA:    rd_nxt = p1_read;
            `PIO_ADDR_P1_ANALOG:  rd_nxt = p1_analog_select_r;
            `PIO_ADDR_P1_DRIVE:   rd_nxt = port1_drive_style_r;
            `PIO_ADDR_P1_MASK:    rd_nxt = port1_compare_mask_r;
            `PIO_ADDR_P1_VALUE:   rd_nxt = port1_compare_value_r;
            `PIO_ADDR_P1_BYPASS:  rd_nxt = p1_bypass_out;
            `PIO_ADDR_P2_DATA:    rd_nxt = p2_read;
            `PIO_ADDR_P2_ANALOG:  rd_nxt = port2_analog_select_r;
            `PIO_ADDR_P2_DRIVE:   rd_nxt = port2_drive_style_r;
            `PIO_ADDR_P2_BYPASS:  rd_nxt = p2_bypass_out;
            `PIO_ADDR_MATCH_CTRL: rd_nxt = {6'h00, match_sticky_r, match_interrupt_enable_r};
            default:              rd_nxt = 8'h00;
        endcase
    end

    // Single-wait-state slave: ack one cycle after strobe, then drop.
    always @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 8'h00;
        end
        else
        begin
            wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
            wb_dat_out <= rd_nxt;
        end
    end

    // Match event, sticky flag (set wins over clear-by-write-one), irq and wake.
    always @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            match_event_out <= 1'b0;
            match_sticky_r  <= 1'b0;
            match_irq_out   <= 1'b0;
            wake_out        <= 1'b0;
        end
        else
        begin
            match_event_out <= mismatch;
            wake_out        <= mismatch;
            if (mismatch)
                match_sticky_r <= 1'b1;
            else if (wr_en && wb_adr_in == `PIO_ADDR_MATCH_CTRL &&
                     wb_dat_in[`PIO_MCTRL_EVENT_BIT])
                match_sticky_r <= 1'b0;
            match_irq_out   <= match_interrupt_enable_r & (match_sticky_r | mismatch);
        end
    end
endmodule

// File: sim/pio_pad_model.sv
`timescale 1ns/10ps
// Pad and board model: the block's driver wins, then the far side, then the pullup.
module pio_pad_model
(
    input  logic       clk_in,
    input  logic [7:0] out_in, oe_in, pu_in, ext_in, ext_en_in,
    output logic [7:0] lvl_out
);
    logic [7:0] flt_r = 8'h55;
    // A pin nobody holds shows a pattern that changes every cycle.
    always @(posedge clk_in) flt_r <= ~flt_r;
    // Resolved wire level fed back to the receiver.
    assign lvl_out = (oe_in & out_in) | (~oe_in & ext_en_in & ext_in)
                   | (~oe_in & ~ext_en_in & (pu_in | flt_r));
endmodule

// File: sim/pio_props_properties.sv
`timescale 1ns/10ps
// Checks bus answers and port 2 pad control as seen at the top-level pins.
module pio_props #(parameter WIDTH = 8)
(
    input logic             sys_clk_in, rstn_in, wb_we_in, wb_sel_in, wb_cyc_in, wb_stb_in,
    input logic             wb_ack_out, match_event_out, wake_out,
    input logic [7:0]       wb_adr_in, wb_dat_in, wb_dat_out,
    input logic [WIDTH-1:0] p2_pad_out, p2_pad_oe_out, p2_pullup_en_out,
    input logic [WIDTH-1:0] p1_bypass_out, p2_bypass_out
);
    logic tk;
    // A write taken at this edge.
    assign tk = wb_cyc_in & wb_stb_in & wb_we_in & wb_sel_in & ~wb_ack_out;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    property p_ack; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
    a_ack: assert property (p_ack) else $error("no answer to a request");
    property p_ack1; wb_ack_out |=> !wb_ack_out; endproperty
    a_ack1: assert property (p_ack1) else $error("answer held too long");
    property p_wake; match_event_out == wake_out; endproperty
    a_wake: assert property (p_wake) else $error("wake differs from event");
    property p_pu_oe; (p2_pullup_en_out & p2_pad_oe_out) == 0; endproperty
    a_pu_oe: assert property (p_pu_oe) else $error("pullup on a driven pin");
    property p_pu_hi; (p2_pullup_en_out & ~p2_pad_out) == 0; endproperty
    a_pu_hi: assert property (p_pu_hi) else $error("pullup on a low latch");
    property p_byp1; !$stable(p1_bypass_out) |-> $past(tk) && $past(wb_adr_in) == 8'hd5
        && $past(wb_dat_in) == p1_bypass_out; endproperty
    a_byp1: assert property (p_byp1) else $error("port 1 bypass changed alone");
    property p_byp2; !$stable(p2_bypass_out) |-> $past(tk) && $past(wb_adr_in) == 8'hd6
        && $past(wb_dat_in) == p2_bypass_out; endproperty
    a_byp2: assert property (p_byp2) else $error("port 2 bypass changed alone");
    property p_unmap; wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out
        && wb_adr_in == 8'h01 |=> wb_dat_out == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    c_wr: cover property (tk);
    c_rd: cover property (wb_ack_out && !wb_we_in);
    c_ev: cover property ($rose(match_event_out));
endmodule
bind pio_port_top pio_props #(.WIDTH(WIDTH)) u_props (.*);

// File: sim/tb_pio_port_top.sv
`timescale 1ns/10ps
// Self-checking bench for the port configuration and match block.
module tb_pio_port_top;
    logic       sys_clk_in = 0, rstn_in = 0, wb_we_in = 0, wb_cyc_in = 0, wb_stb_in = 0;
    logic       wb_sel_in = 1;
    logic [7:0] wb_adr_in = 0, wb_dat_in = 0, ext_r = 0, ext_en_r = 0, rd;
    wire  [7:0] wb_dat_out, p1_pad_in, p1_pad_out, p1_pad_oe_out, p1_pullup_en_out;
    wire  [7:0] p2_pad_in, p2_pad_out, p2_pad_oe_out, p2_pullup_en_out;
    wire  [7:0] p1_bypass_out, p2_bypass_out;
    wire        wb_ack_out, match_event_out, match_irq_out, wake_out;
    int         num_errors = 0, num_checks = 0, cyc_n = 0;
    // Rows: address, reset value, value written, value read back.
    logic [7:0] tab [8][4] = '{'{8'ha0, 8'hff, 8'hff, 8'hff}, '{8'ha5, 8'h00, 8'h3c, 8'h3c},
        '{8'ha6, 8'h00, 8'hc3, 8'hc3}, '{8'hbf, 8'h00, 8'h5a, 8'h5a},
        '{8'hcf, 8'hff, 8'h7e, 8'h7e}, '{8'hd5, 8'h00, 8'ha5, 8'ha5},
        '{8'hd6, 8'h00, 8'h5a, 8'h5a}, '{8'h01, 8'h00, 8'h5a, 8'h00}};
    pio_port_top dut_u (.*);
    pio_pad_model p1m (.clk_in(sys_clk_in), .out_in(p1_pad_out), .oe_in(p1_pad_oe_out),
        .pu_in(p1_pullup_en_out), .ext_in(ext_r), .ext_en_in(ext_en_r), .lvl_out(p1_pad_in));
    pio_pad_model p2m (.clk_in(sys_clk_in), .out_in(p2_pad_out), .oe_in(p2_pad_oe_out),
        .pu_in(p2_pullup_en_out), .ext_in(8'h00), .ext_en_in(8'h00), .lvl_out(p2_pad_in));
    // Clock at 20 MHz.
    initial forever #25 sys_clk_in = ~sys_clk_in;
    // Ends a hung run.
    always @(posedge sys_clk_in) if (++cyc_n == 3000) stop_test(1);
    // One classic bus cycle, held until the answer is sampled.
    task bus(input [7:0] a, d, input w);
        @(posedge sys_clk_in);
        {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, w, a, d};
        do @(posedge sys_clk_in); while (wb_ack_out !== 1'b1);
        rd = wb_dat_out;
        {wb_cyc_in, wb_stb_in} <= 2'b00;
    endtask
    // Compares one value and counts it.
    task chk(input [7:0] got, exp);
        num_checks++;
        if (got !== exp) $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        if (got !== exp) num_errors++;
    endtask
    // Prints the counts and the verdict.
    task stop_test(input int t);
        num_errors += t;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Main sequence: table loop, then directed cases.
    initial
    begin
        repeat (12) @(posedge sys_clk_in);
        rstn_in <= 1;
        // The pin cells need two edges before pullups settle and pin reads become valid.
        repeat (2) @(posedge sys_clk_in);
        foreach (tab[i])
        begin
            bus(tab[i][0], 8'h00, 1'b0);
            chk(rd, tab[i][1]);
            bus(tab[i][0], tab[i][2], 1'b1);
            bus(tab[i][0], 8'h00, 1'b0);
            chk(rd, tab[i][3]);
        end
        chk(p1_bypass_out, 8'ha5);
        chk(p2_bypass_out, 8'h5a);
        // Port 2: mixed drive styles, analog pin 7 keeps a 1 in its latch.
        bus(8'ha6, 8'h0f, 1'b1);
        bus(8'ha0, 8'hb5, 1'b1);
        bus(8'hf3, 8'h7f, 1'b1);
        repeat (3) @(posedge sys_clk_in);
        chk(p2_pad_oe_out, 8'h4f);
        chk(p2_pad_out & 8'h4f, 8'h05);
        chk(p2_pullup_en_out, 8'h30);
        bus(8'ha0, 8'h00, 1'b0);
        chk(rd, 8'h35);
        bus(8'hd6, 8'h80, 1'b1);
        chk(p2_bypass_out, 8'h80);
        // Port 1: drive style ignored on the analog pin.
        bus(8'ha5, 8'hff, 1'b1);
        bus(8'hf2, 8'hfe, 1'b1);
        repeat (3) @(posedge sys_clk_in);
        chk(p1_pad_oe_out, 8'hfe);
        chk(p1_pullup_en_out, 8'h00);
        chk(p1_pad_out, 8'hff);
        bus(8'h90, 8'h00, 1'b0);
        chk(rd, 8'hfe);
        // Match: low nibble compared, upper nibble masked off.
        bus(8'ha5, 8'h00, 1'b1);
        bus(8'hf2, 8'hff, 1'b1);
        bus(8'hbf, 8'h0f, 1'b1);
        bus(8'hcf, 8'h0a, 1'b1);
        {ext_r, ext_en_r} <= 16'hfaff;
        repeat (4) @(posedge sys_clk_in);
        chk({5'h00, match_event_out, wake_out, match_irq_out}, 8'h00);
        ext_r <= 8'h0a;
        repeat (4) @(posedge sys_clk_in);
        chk({5'h00, match_event_out, wake_out, match_irq_out}, 8'h00);
        ext_r <= 8'h0b;
        repeat (4) @(posedge sys_clk_in);
        chk({5'h00, match_event_out, wake_out, match_irq_out}, 8'h06);
        bus(8'he0, 8'h01, 1'b1);
        ext_r <= 8'h0a;
        repeat (4) @(posedge sys_clk_in);
        chk({5'h00, match_event_out, wake_out, match_irq_out}, 8'h01);
        bus(8'he0, 8'h03, 1'b1);
        repeat (2) @(posedge sys_clk_in);
        chk({7'h00, match_irq_out}, 8'h00);
        // Reset in mid-run restores the configuration.
        rstn_in <= 0;
        repeat (3) @(posedge sys_clk_in);
        chk(p1_bypass_out, 8'h00);
        rstn_in <= 1;
        bus(8'ha6, 8'h00, 1'b0);
        chk(rd, 8'h00);
        stop_test(0);
    end
endmodule
